/* File: rtl/tve_pkg.sv */
// Package with register map, field positions, reset values and codes of the video config block.
package tve_pkg;

   localparam logic [7:0] TVE_ADDR_VIDEO_FILTER_BANDWIDTH    = 8'h03;
   localparam logic [7:0] TVE_ADDR_INPUT_PIXEL_FORMAT        = 8'h04;
   localparam logic [7:0] TVE_ADDR_CLOCKING_MODE             = 8'h06;
   localparam logic [7:0] TVE_ADDR_ACTIVE_VIDEO_START_DELAY  = 8'h07;
   localparam logic [7:0] TVE_ADDR_POSITION_MSB_OVERFLOW     = 8'h08;
   localparam logic [7:0] TVE_ADDR_BLACK_LEVEL               = 8'h09;
   localparam logic [7:0] TVE_ADDR_HORIZONTAL_IMAGE_POSITION = 8'h0A;

   // Writable bit masks; bits outside a mask are unused.
   localparam logic [7:0] TVE_MASK_FILTER   = 8'hFF;
   localparam logic [7:0] TVE_MASK_FORMAT   = 8'h6F;
   localparam logic [7:0] TVE_MASK_CLOCKING = 8'hDF;
   localparam logic [7:0] TVE_MASK_POSITION = 8'h07;
   localparam logic [7:0] TVE_MASK_FULL     = 8'hFF;

   localparam logic [7:0] TVE_RST_FILTER    = 8'h00;
   localparam logic [7:0] TVE_RST_FORMAT    = 8'h00;
   localparam logic [7:0] TVE_RST_CLOCKING  = 8'h10;
   localparam logic [7:0] TVE_RST_START     = 8'h00;
   localparam logic [7:0] TVE_RST_POSITION  = 8'h00;
   localparam logic [7:0] TVE_RST_BLACK     = 8'h7F;
   localparam logic [7:0] TVE_RST_HPOS      = 8'h10;
   localparam logic [7:0] TVE_RDATA_UNMAPPED = 8'h00;

   // Field positions in the filter bandwidth register.
   localparam int TVE_COMP_LUMA_BIT  = 0;
   localparam int TVE_SV_LUMA_LSB    = 1;
   localparam int TVE_PEAKING_BIT    = 3;
   localparam int TVE_CHROMA_LSB     = 4;
   localparam int TVE_MONO_BIT       = 6;
   localparam int TVE_FIVE_LINE_BIT  = 7;
   // Field positions in the input pixel format register.
   localparam int TVE_FORMAT_LSB     = 0;
   localparam int TVE_BYPASS_BIT     = 5;
   localparam int TVE_GAIN_BIT       = 6;
   // Field positions in the clocking mode register.
   localparam int TVE_PIX_MULT_LSB   = 0;
   localparam int TVE_IN_MULT_LSB    = 2;
   localparam int TVE_LATCH_EDGE_BIT = 4;
   localparam int TVE_MASTER_BIT     = 6;
   localparam int TVE_SUBC_LOCK_BIT  = 7;
   // Field positions in the position overflow register.
   localparam int TVE_VPOS_MSB_BIT   = 0;
   localparam int TVE_HPOS_MSB_BIT   = 1;
   localparam int TVE_START_MSB_BIT  = 2;

   localparam logic [6:0] TVE_DAC_UA_LOW  = 7'h47;
   localparam logic [6:0] TVE_DAC_UA_HIGH = 7'h4C;
   localparam logic [1:0] TVE_SV_RESERVED = 2'h3;
   localparam logic [1:0] TVE_SV_HIGH     = 2'h2;
   localparam logic [4:0] TVE_BUS_16      = 5'h10;
   localparam logic [4:0] TVE_BUS_15      = 5'h0F;
   localparam logic [4:0] TVE_BUS_12      = 5'h0C;
   localparam logic [4:0] TVE_BUS_8       = 5'h08;
   localparam logic [4:0] TVE_COLOR_24    = 5'h18;
   localparam int         TVE_HPOS_STEP_SHIFT = 2;

   typedef enum logic [3:0] {
      TVE_FMT_RGB565_16  = 4'h0,
      TVE_FMT_YCRCB_16   = 4'h1,
      TVE_FMT_RGB24_M16  = 4'h2,
      TVE_FMT_RGB555_15  = 4'h3,
      TVE_FMT_RGB24_C12  = 4'h4,
      TVE_FMT_RGB24_I12  = 4'h5,
      TVE_FMT_RGB888_8   = 4'h6,
      TVE_FMT_RGB565_8   = 4'h7,
      TVE_FMT_RGB555_8   = 4'h8,
      TVE_FMT_YCRCB_8    = 4'h9
   } tve_fmt_e;

   typedef enum logic [1:0] {
      TVE_MULT_1X = 2'h1,
      TVE_MULT_2X = 2'h2,
      TVE_MULT_3X = 2'h3
   } tve_mult_e;

endpackage

/* File: rtl/tve_cfg_if.sv */
// Interface carrying register images from the register bank to the clocking decoder.
interface tve_cfg_if;
   logic [7:0] clk_mode;
   logic [7:0] start_low;
   logic [7:0] pos_msb;
   logic [7:0] hpos;
   logic       scart_en;

   modport regs (output clk_mode, output start_low, output pos_msb, output hpos,
                 output scart_en);
   modport dec  (input clk_mode, input start_low, input pos_msb, input hpos,
                 input scart_en);
endinterface

/* File: rtl/tve_clk_pos_decode.sv */
// Decoder for clocking modes, position values and output routing.
module tve_clk_pos_decode
   import tve_pkg::*;
(
   input  logic              mclk,
   input  logic              rst,
   tve_cfg_if.dec            cfg,
   output tve_pkg::tve_mult_e in_clk_mult,
   output tve_pkg::tve_mult_e pix_clk_mult,
   output logic              latch_rising,
   output logic              pll_master,
   output tve_pkg::tve_mult_e pll_ref_div,
   output logic              pll_n_one,
   output logic              subcarrier_locked,
   output logic [8:0]        active_start_delay,
   output logic [8:0]        hpos_value,
   output logic [10:0]       hpos_shift_px,
   output logic              vpos_msb,
   output logic              dac_rgb_sel,
   output logic              csync_en
);
   import tve_pkg::*;

   typedef struct packed {
      tve_mult_e   in_mult;
      tve_mult_e   pix_mult;
      logic        latch_rising;
      logic        master;
      tve_mult_e   ref_div;
      logic        n_one;
      logic        subc_lock;
      logic [8:0]  start_delay;
      logic [8:0]  hpos;
      logic [10:0] shift_px;
      logic        vpos_msb;
      logic        rgb_sel;
      logic        csync;
   } tve_dec_s;

   tve_dec_s st;
   tve_dec_s next_st;

   function automatic tve_mult_e mult_of(input logic [1:0] code);
      case (code)
         2'h0:    mult_of = TVE_MULT_1X;
         2'h1:    mult_of = TVE_MULT_2X;
         default: mult_of = TVE_MULT_3X;
      endcase
   endfunction

   always_comb begin
      next_st = st;
      next_st.in_mult  = mult_of(cfg.clk_mode[TVE_IN_MULT_LSB +: 2]);
      next_st.pix_mult = mult_of(cfg.clk_mode[TVE_PIX_MULT_LSB +: 2]);
      next_st.latch_rising = cfg.clk_mode[TVE_LATCH_EDGE_BIT];
      next_st.master  = cfg.clk_mode[TVE_MASTER_BIT];
      next_st.ref_div = cfg.clk_mode[TVE_MASTER_BIT] ? TVE_MULT_1X : next_st.in_mult;
      next_st.n_one   = !cfg.clk_mode[TVE_MASTER_BIT];
      next_st.subc_lock = cfg.clk_mode[TVE_SUBC_LOCK_BIT];
      next_st.start_delay = {cfg.pos_msb[TVE_START_MSB_BIT], cfg.start_low};
      next_st.hpos     = {cfg.pos_msb[TVE_HPOS_MSB_BIT], cfg.hpos};
      next_st.vpos_msb = cfg.pos_msb[TVE_VPOS_MSB_BIT];
      next_st.shift_px = {next_st.hpos, 2'h0};
      next_st.rgb_sel = cfg.scart_en;
      next_st.csync   = cfg.scart_en;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st <= '{in_mult: TVE_MULT_1X, pix_mult: TVE_MULT_1X, latch_rising: 1'b1,
                 master: 1'b0, ref_div: TVE_MULT_1X, n_one: 1'b1, subc_lock: 1'b0,
                 start_delay: 9'h000, hpos: 9'h010, shift_px: 11'h040,
                 vpos_msb: 1'b0, rgb_sel: 1'b0, csync: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign in_clk_mult        = st.in_mult;
   assign pix_clk_mult       = st.pix_mult;
   assign latch_rising       = st.latch_rising;
   assign pll_master         = st.master;
   assign pll_ref_div        = st.ref_div;
   assign pll_n_one          = st.n_one;
   assign subcarrier_locked  = st.subc_lock;
   assign active_start_delay = st.start_delay;
   assign hpos_value         = st.hpos;
   assign hpos_shift_px      = st.shift_px;
   assign vpos_msb           = st.vpos_msb;
   assign dac_rgb_sel        = st.rgb_sel;
   assign csync_en           = st.csync;

   default clocking dc @(posedge mclk); endclocking
   default disable iff (rst);

   chk_latch_edge_follow: assert property (
      ##1 latch_rising == $past(cfg.clk_mode[TVE_LATCH_EDGE_BIT]))
      else $error("latch edge does not follow the clocking mode bit");
   chk_pll_slave_div: assert property (
      !cfg.clk_mode[TVE_MASTER_BIT] && cfg.clk_mode[TVE_IN_MULT_LSB +: 2] == 2'h1
      |=> pll_ref_div == TVE_MULT_2X && pll_n_one && !pll_master)
      else $error("slave PLL reference divider wrong");
   chk_start_delay_msb: assert property (
      cfg.pos_msb[TVE_START_MSB_BIT] |=> active_start_delay[8])
      else $error("start delay MSB not taken from overflow bit");
   chk_hpos_shift_step: assert property (
      ##1 hpos_shift_px == {$past({cfg.pos_msb[TVE_HPOS_MSB_BIT], cfg.hpos}), 2'h0})
      else $error("horizontal shift is not four pixels per step");
   chk_scart_routing: assert property (
      $rose(cfg.scart_en) |=> dac_rgb_sel && csync_en)
      else $error("SCART mode did not route RGB and composite sync");
   cov_three_x_input: cover property (in_clk_mult == TVE_MULT_3X);
   cov_master_mode:   cover property (pll_master && subcarrier_locked);
endmodule

/* File: rtl/tve_video_cfg.sv */
// Video configuration register bank with filter, format and black level logic.
//
// Overview of operation
// - Composite luma filter bit picks low bandwidth at 0, high at 1.
// - S-Video luma field selects low, medium, high; code 11 acts as 10.
// - Peaking bit enables S-Video luma peaking at 1, bypasses it at 0.
// - Chroma field picks low, medium, medium-high or high bandwidth.
// - Monochrome bit drives S-Video luma onto composite output too.
// - In 7/10 scaling, filter length bit picks five lines, else four.
// - Format codes 0 to 3 are 565, 16-bit YCrCb, muxed 24-bit, 555.
// - Codes 4, 5 are 12-bit C and I schemes; 6 to 8 are 8-bit RGB.
// - Codes 9 through 15 are 8-bit multiplexed YCrCb with 24-bit colour.
// - Bypass bit routes input RGB to the DACs after a pipeline delay.
// - Gain bit picks 71 microamps at 0 and 76 microamps at 1.
// - Input and pixel clock multiple fields give 1X, 2X or 3X.
// - Latch edge bit picks falling edge at 0, rising at 1; resets to 1.
// - Master mode uses the crystal reference; slave uses divided input, N one.
// - Subcarrier lock bit locks to vertical rate at 1, free-runs at 0.
// - Active video start delay is nine bits, MSB from overflow bit 2.
// - Overflow bit 0 is vertical MSB, bit 1 horizontal MSB.
// - Luma is added to black level, reset 127; software keeps 90 to 208.
// - Horizontal position moves the image four input pixels per step.
// - SCART mode makes DACs output RGB and enables composite sync pin.
module tve_video_cfg
   import tve_pkg::*;
(
   input  logic              mclk,
   input  logic              rst,
   input  logic [7:0]        reg_addr,
   input  logic              reg_wr,
   input  logic              reg_rd,
   input  logic [7:0]        reg_wdata,
   output logic [7:0]        reg_rdata,
   input  logic              scart_en,
   input  logic              scale_7_10,
   input  logic [7:0]        luma_in,
   output logic [8:0]        luma_out,
   output logic              comp_luma_wide,
   output logic [1:0]        svideo_luma_bw,
   output logic              luma_peaking_on,
   output logic [1:0]        chroma_bw,
   output logic              composite_mono,
   output logic              five_line_on,
   output tve_pkg::tve_fmt_e input_format,
   output logic [4:0]        input_bus_bits,
   output logic [4:0]        input_color_bits,
   output logic              input_ycrcb,
   output logic              rgb_bypass_on,
   output logic [6:0]        dac_current_ua,
   output tve_pkg::tve_mult_e in_clk_mult,
   output tve_pkg::tve_mult_e pix_clk_mult,
   output logic              latch_rising,
   output logic              pll_master,
   output tve_pkg::tve_mult_e pll_ref_div,
   output logic              pll_n_one,
   output logic              subcarrier_locked,
   output logic [8:0]        active_start_delay,
   output logic [8:0]        hpos_value,
   output logic [10:0]       hpos_shift_px,
   output logic              vpos_msb,
   output logic              dac_rgb_sel,
   output logic              csync_en
);
   import tve_pkg::*;

   typedef struct packed {
      logic [7:0] filt;
      logic [7:0] fmt;
      logic [7:0] clk_mode;
      logic [7:0] start_low;
      logic [7:0] pos_msb;
      logic [7:0] black;
      logic [7:0] hpos;
      logic [7:0] rdata;
      logic [8:0] luma;
      logic       comp_wide;
      logic [1:0] sv_bw;
      logic       peak;
      logic [1:0] chroma;
      logic       mono;
      logic       five_line;
      tve_fmt_e   fmt_dec;
      logic [4:0] bus_bits;
      logic [4:0] color_bits;
      logic       ycrcb;
      logic       bypass;
      logic [6:0] dac_ua;
   } tve_top_s;

   tve_top_s  st;
   tve_top_s  next_st;
   tve_cfg_if cfg ();

   always_comb begin
      next_st = st;
      if (reg_wr) begin
         case (reg_addr)
            TVE_ADDR_VIDEO_FILTER_BANDWIDTH:    next_st.filt = reg_wdata & TVE_MASK_FILTER;
            TVE_ADDR_INPUT_PIXEL_FORMAT:        next_st.fmt = reg_wdata & TVE_MASK_FORMAT;
            TVE_ADDR_CLOCKING_MODE:             next_st.clk_mode = reg_wdata & TVE_MASK_CLOCKING;
            TVE_ADDR_ACTIVE_VIDEO_START_DELAY:  next_st.start_low = reg_wdata & TVE_MASK_FULL;
            TVE_ADDR_POSITION_MSB_OVERFLOW:     next_st.pos_msb = reg_wdata & TVE_MASK_POSITION;
            TVE_ADDR_BLACK_LEVEL:               next_st.black = reg_wdata & TVE_MASK_FULL;
            TVE_ADDR_HORIZONTAL_IMAGE_POSITION: next_st.hpos = reg_wdata & TVE_MASK_FULL;
            default: ;
         endcase
      end
      // Reads return the value held before any write in the same cycle.
      if (reg_rd) begin
         case (reg_addr)
            TVE_ADDR_VIDEO_FILTER_BANDWIDTH:    next_st.rdata = st.filt;
            TVE_ADDR_INPUT_PIXEL_FORMAT:        next_st.rdata = st.fmt;
            TVE_ADDR_CLOCKING_MODE:             next_st.rdata = st.clk_mode;
            TVE_ADDR_ACTIVE_VIDEO_START_DELAY:  next_st.rdata = st.start_low;
            TVE_ADDR_POSITION_MSB_OVERFLOW:     next_st.rdata = st.pos_msb;
            TVE_ADDR_BLACK_LEVEL:               next_st.rdata = st.black;
            TVE_ADDR_HORIZONTAL_IMAGE_POSITION: next_st.rdata = st.hpos;
            default:                            next_st.rdata = TVE_RDATA_UNMAPPED;
         endcase
      end
      // luma rides on the black level
      next_st.luma = {1'b0, st.black} + {1'b0, luma_in};
      next_st.comp_wide = st.filt[TVE_COMP_LUMA_BIT];
      // reserved S-Video code folds onto high
      if (st.filt[TVE_SV_LUMA_LSB +: 2] == TVE_SV_RESERVED) begin
         next_st.sv_bw = TVE_SV_HIGH;
      end else begin
         next_st.sv_bw = st.filt[TVE_SV_LUMA_LSB +: 2];
      end
      next_st.peak = st.filt[TVE_PEAKING_BIT];
      next_st.chroma = st.filt[TVE_CHROMA_LSB +: 2];
      next_st.mono = st.filt[TVE_MONO_BIT];
      // five-line filter only in 7/10 scaling
      next_st.five_line = st.filt[TVE_FIVE_LINE_BIT] && scale_7_10;
      next_st.bypass = st.fmt[TVE_BYPASS_BIT];
      next_st.dac_ua = st.fmt[TVE_GAIN_BIT] ? TVE_DAC_UA_HIGH : TVE_DAC_UA_LOW;
      next_st.ycrcb = 1'b0;
      // sixteen, fifteen, twelve and eight bit formats
      // all high codes are 8-bit YCrCb
      case (st.fmt[TVE_FORMAT_LSB +: 4])
         4'h0: begin
            next_st.fmt_dec    = TVE_FMT_RGB565_16;
            next_st.bus_bits   = TVE_BUS_16;
            next_st.color_bits = TVE_BUS_16;
         end
         4'h1: begin
            next_st.fmt_dec    = TVE_FMT_YCRCB_16;
            next_st.bus_bits   = TVE_BUS_16;
            next_st.color_bits = TVE_COLOR_24;
            next_st.ycrcb      = 1'b1;
         end
         4'h2: begin
            next_st.fmt_dec    = TVE_FMT_RGB24_M16;
            next_st.bus_bits   = TVE_BUS_16;
            next_st.color_bits = TVE_COLOR_24;
         end
         4'h3: begin
            next_st.fmt_dec    = TVE_FMT_RGB555_15;
            next_st.bus_bits   = TVE_BUS_15;
            next_st.color_bits = TVE_BUS_15;
         end
         4'h4: begin
            next_st.fmt_dec    = TVE_FMT_RGB24_C12;
            next_st.bus_bits   = TVE_BUS_12;
            next_st.color_bits = TVE_COLOR_24;
         end
         4'h5: begin
            next_st.fmt_dec    = TVE_FMT_RGB24_I12;
            next_st.bus_bits   = TVE_BUS_12;
            next_st.color_bits = TVE_COLOR_24;
         end
         4'h6: begin
            next_st.fmt_dec    = TVE_FMT_RGB888_8;
            next_st.bus_bits   = TVE_BUS_8;
            next_st.color_bits = TVE_COLOR_24;
         end
         4'h7: begin
            next_st.fmt_dec    = TVE_FMT_RGB565_8;
            next_st.bus_bits   = TVE_BUS_8;
            next_st.color_bits = TVE_BUS_16;
         end
         4'h8: begin
            next_st.fmt_dec    = TVE_FMT_RGB555_8;
            next_st.bus_bits   = TVE_BUS_8;
            next_st.color_bits = TVE_BUS_15;
         end
         default: begin
            next_st.fmt_dec    = TVE_FMT_YCRCB_8;
            next_st.bus_bits   = TVE_BUS_8;
            next_st.color_bits = TVE_COLOR_24;
            next_st.ycrcb      = 1'b1;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st <= '{filt: TVE_RST_FILTER, fmt: TVE_RST_FORMAT, clk_mode: TVE_RST_CLOCKING,
                 start_low: TVE_RST_START, pos_msb: TVE_RST_POSITION,
                 black: TVE_RST_BLACK, hpos: TVE_RST_HPOS, rdata: 8'h00,
                 luma: 9'h07F, comp_wide: 1'b0, sv_bw: 2'h0, peak: 1'b0,
                 chroma: 2'h0, mono: 1'b0, five_line: 1'b0,
                 fmt_dec: TVE_FMT_RGB565_16, bus_bits: 5'h10, color_bits: 5'h10,
                 ycrcb: 1'b0, bypass: 1'b0, dac_ua: 7'h47};
      end else begin
         st <= next_st;
      end
   end

   assign cfg.clk_mode  = st.clk_mode;
   assign cfg.start_low = st.start_low;
   assign cfg.pos_msb   = st.pos_msb;
   assign cfg.hpos      = st.hpos;
   assign cfg.scart_en  = scart_en;

   tve_clk_pos_decode u_clk_pos (
      .mclk               (mclk),
      .rst                (rst),
      .cfg                (cfg),
      .in_clk_mult        (in_clk_mult),
      .pix_clk_mult       (pix_clk_mult),
      .latch_rising       (latch_rising),
      .pll_master         (pll_master),
      .pll_ref_div        (pll_ref_div),
      .pll_n_one          (pll_n_one),
      .subcarrier_locked  (subcarrier_locked),
      .active_start_delay (active_start_delay),
      .hpos_value         (hpos_value),
      .hpos_shift_px      (hpos_shift_px),
      .vpos_msb           (vpos_msb),
      .dac_rgb_sel        (dac_rgb_sel),
      .csync_en           (csync_en)
   );

   assign reg_rdata        = st.rdata;
   assign luma_out         = st.luma;
   assign comp_luma_wide   = st.comp_wide;
   assign svideo_luma_bw   = st.sv_bw;
   assign luma_peaking_on  = st.peak;
   assign chroma_bw        = st.chroma;
   assign composite_mono   = st.mono;
   assign five_line_on     = st.five_line;
   assign input_format     = st.fmt_dec;
   assign input_bus_bits   = st.bus_bits;
   assign input_color_bits = st.color_bits;
   assign input_ycrcb      = st.ycrcb;
   assign rgb_bypass_on    = st.bypass;
   assign dac_current_ua   = st.dac_ua;

   default clocking dc @(posedge mclk); endclocking
   default disable iff (rst);

   chk_black_readback: assert property (
      reg_wr && reg_addr == TVE_ADDR_BLACK_LEVEL
      ##1 reg_rd && !reg_wr && reg_addr == TVE_ADDR_BLACK_LEVEL
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("black level read back differs from written value");
   chk_unused_zero: assert property (
      reg_rd && reg_addr == TVE_ADDR_INPUT_PIXEL_FORMAT
      |=> reg_rdata[7] == 1'b0 && reg_rdata[4] == 1'b0)
      else $error("unused format bits read as one");
   chk_comp_luma_sel: assert property (
      reg_wr && reg_addr == TVE_ADDR_VIDEO_FILTER_BANDWIDTH
      |=> ##1 comp_luma_wide == $past(reg_wdata[TVE_COMP_LUMA_BIT], 2))
      else $error("composite luma bandwidth does not follow its bit");
   chk_svideo_reserved: assert property (
      reg_wr && reg_addr == TVE_ADDR_VIDEO_FILTER_BANDWIDTH
      && reg_wdata[TVE_SV_LUMA_LSB +: 2] == TVE_SV_RESERVED
      |=> ##1 svideo_luma_bw == TVE_SV_HIGH)
      else $error("reserved S-Video luma code not treated as high");
   chk_five_line_mode: assert property (
      five_line_on |-> $past(scale_7_10))
      else $error("five-line filter used outside 7/10 scaling");
   chk_wide_format: assert property (
      reg_wr && reg_addr == TVE_ADDR_INPUT_PIXEL_FORMAT && reg_wdata[3:0] >= 4'h9
      |=> ##1 input_format == TVE_FMT_YCRCB_8 && input_bus_bits == TVE_BUS_8
      && input_ycrcb)
      else $error("high format code not decoded as 8-bit YCrCb");
   chk_dac_gain_sel: assert property (
      reg_wr && reg_addr == TVE_ADDR_INPUT_PIXEL_FORMAT && reg_wdata[TVE_GAIN_BIT]
      |=> ##1 dac_current_ua == TVE_DAC_UA_HIGH)
      else $error("DAC gain bit did not select the high current");
   chk_luma_sum: assert property (
      ##2 luma_out == {1'b0, $past(luma_in)} + {1'b0, $past(st.black)})
      else $error("luma output is not black level plus luma");
   cov_bypass_write: cover property (reg_wr && reg_addr == TVE_ADDR_INPUT_PIXEL_FORMAT
      && reg_wdata[TVE_BYPASS_BIT] ##2 rgb_bypass_on);
   cov_mono_scart: cover property (composite_mono && dac_rgb_sel);
   cov_unmapped_read: cover property (reg_rd && reg_addr == 8'h05);
endmodule

/* File: verif/tb_tve_video_cfg.sv */
// Self-checking bench for the video configuration register bank.
module tb_tve_video_cfg;
   timeunit 1ns;
   timeprecision 1ps;
   import tve_pkg::*;
   logic       mclk, rst, reg_wr, reg_rd, scart_en, scale_7_10, comp_luma_wide, luma_peaking_on;
   logic       composite_mono, five_line_on, input_ycrcb, rgb_bypass_on, latch_rising;
   logic       pll_master, pll_n_one, subcarrier_locked, vpos_msb, dac_rgb_sel, csync_en;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, luma_in, f, g, c, s, p, h, b;
   logic [8:0] luma_out, active_start_delay, hpos_value;
   logic [1:0] svideo_luma_bw, chroma_bw;
   logic [4:0] input_bus_bits, input_color_bits;
   logic [6:0] dac_current_ua;
   logic [10:0] hpos_shift_px;
   logic [3:0] fm;
   tve_fmt_e   input_format;
   tve_mult_e  in_clk_mult, pix_clk_mult, pll_ref_div;
   int         n_fail, check_count, i;
   logic [31:0] sd = 32'h0002;
   logic [7:0] ad[8] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h05};
   logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h7F, 8'h10, 8'h00};
   logic [7:0] mk[8] = '{8'hFF, 8'h6F, 8'hDF, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'h00};

   tve_video_cfg u_tve_video_cfg (.*);

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   function automatic logic [7:0] lfsr();
      sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
      return sd[7:0];
   endfunction

   function automatic logic [1:0] mu(input logic [1:0] x);
      return x[1] ? 2'h3 : x + 2'h1;
   endfunction

   task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] got);
      check_count++;
      if (e !== got) begin
         $display("mismatch %s exp %0h got %0h", nm, e, got);
         n_fail++;
      end
   endtask

   // Inputs move at the falling edge; decoded outputs settle one edge after the register.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk) reg_wr = 1'b0;
      @(negedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk) reg_rd = 1'b0;
      @(negedge mclk) chk("reg_rdata", {3'h0, e}, {3'h0, reg_rdata});
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #1ms n_fail++;
      wrap_up();
   end

   initial begin
      {rst, reg_wr, reg_rd, scart_en, scale_7_10} = 5'h10;
      {reg_addr, reg_wdata, luma_in} = 24'h0;
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      for (i = 0; i < 8; i++) rd(ad[i], rv[i]);
      chk("latch_rising", 11'h1, {10'h0, latch_rising});
      $display("test reset done");
      // A read right behind a write, then a read beside a write of the same offset.
      reg_addr = 8'h09;
      reg_wdata = 8'h64;
      reg_wr = 1'b1;
      @(negedge mclk) reg_rd = 1'b1;
      reg_wr = 1'b0;
      @(negedge mclk) chk("black_b2b", 11'h064, {3'h0, reg_rdata});
      reg_wr = 1'b1;
      reg_wdata = 8'h5A;
      @(negedge mclk) chk("black_old", 11'h064, {3'h0, reg_rdata});
      reg_wr = 1'b0;
      @(negedge mclk) chk("black_new", 11'h05A, {3'h0, reg_rdata});
      reg_rd = 1'b0;
      $display("test back to back done");
      for (i = 0; i < 32; i++) begin
         b = lfsr();
         b = (i % 8 == 5) ? 8'h5A + b % 8'h77 : b;
         wr(ad[i % 8], b);
         rd(ad[i % 8], b & mk[i % 8]);
      end
      $display("test mask done");
      for (i = 0; i < 32; i++) begin
         {f, c, s, p, h, b} = {lfsr(), lfsr(), lfsr(), lfsr(), lfsr(), lfsr()};
         g = (lfsr() & 8'h60) | i[3:0];
         c[3:2] = (g[3:0] == 4'h6) ? {1'b1, c[2]} :
                  (g[3:0] inside {4'h0, 4'h1, 4'h3}) ? 2'h0 : {1'b0, c[2]};
         s = (c[3:0] != 4'h0) ? s - s % 8'h06 : s;
         p[2] = p[2] & (c[3:0] == 4'h0);
         {scale_7_10, scart_en} = c[1:0] ^ s[1:0];
         b = scart_en ? 8'h00 : 8'h5A + b % 8'h77;
         wr(8'h03, f);
         wr(8'h04, g);
         wr(8'h06, c);
         wr(8'h07, s);
         wr(8'h08, p);
         wr(8'h0A, h);
         fm = (g[3:0] > 4'h9) ? 4'h9 : g[3:0];
         chk("comp_luma", f[0], comp_luma_wide);
         chk("sv_luma", (f[2:1] == 2'h3) ? 2'h2 : f[2:1], svideo_luma_bw);
         chk("peaking", f[3], luma_peaking_on);
         chk("chroma", f[5:4], chroma_bw);
         chk("mono", f[6], composite_mono);
         chk("five_line", f[7] & scale_7_10, five_line_on);
         chk("format", fm, input_format);
         chk("ycrcb", fm == 4'h1 || fm == 4'h9, input_ycrcb);
         chk("bus", fm < 3 ? 16 : fm == 3 ? 15 : fm < 6 ? 12 : 8, input_bus_bits);
         chk("color", fm inside {0, 7} ? 16 : fm inside {3, 8} ? 15 : 24, input_color_bits);
         chk("bypass", g[5], rgb_bypass_on);
         chk("dac_ua", g[6] ? 76 : 71, dac_current_ua);
         chk("in_mult", mu(c[3:2]), in_clk_mult);
         chk("pix_mult", mu(c[1:0]), pix_clk_mult);
         chk("latch", c[4], latch_rising);
         chk("master", c[6], pll_master);
         chk("n_one", !c[6], pll_n_one);
         chk("ref_div", c[6] ? 2'h1 : mu(c[3:2]), pll_ref_div);
         chk("lock", c[7], subcarrier_locked);
         chk("start", {p[2], s}, active_start_delay);
         chk("hpos", {p[1], h}, hpos_value);
         chk("vpos", p[0], vpos_msb);
         chk("hshift", {p[1], h, 2'h0}, hpos_shift_px);
         chk("dac_rgb", scart_en, dac_rgb_sel);
         chk("csync", scart_en, csync_en);
         wr(8'h09, b);
         luma_in = lfsr();
         @(negedge mclk) chk("luma", b + luma_in, luma_out);
      end
      $display("test decode done");
      wrap_up();
   end
endmodule
